// ### shared/hsi_pkg.sv
package hsi_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD      = 8'h00;
    localparam logic [7:0] ADDR_CFG      = 8'h04;
    localparam logic [7:0] ADDR_STAT     = 8'h08;
    localparam logic [7:0] ADDR_QSEL     = 8'h0C;
    localparam logic [7:0] ADDR_QDATA    = 8'h10;
    localparam logic [7:0] ADDR_IDX      = 8'h14;
    localparam logic [7:0] ADDR_IDENT    = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CMD_START_BIT  = 0;
    localparam int CMD_DIR_LSB    = 1;
    localparam int CMD_ABORT_BIT  = 3;
    localparam int CFG_SRC_LSB    = 0;
    localparam int CFG_AUTO_BIT   = 2;
    localparam int CFG_DRV_BIT    = 3;
    localparam int CFG_LINK_BIT   = 4;
    localparam int CFG_DEFIDX_LSB = 8;
    localparam int QSEL_SEL_LSB   = 0;
    localparam int QSEL_GIVEN_BIT = 4;
    localparam int QSEL_UNIT_BIT  = 5;
    localparam int QSEL_SN_BIT    = 6;
    localparam int IDX_SRC_LSB    = 0;
    localparam int IDX_GIVEN_BIT  = 2;
    localparam int IRQ_FOUND_BIT  = 0;
    localparam int IRQ_FAIL_BIT   = 1;
    localparam int IRQ_ERR_BIT    = 2;
    localparam int IRQ_WIDTH      = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
    localparam logic [31:0] QSEL_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] DIR_POS  = 2'h1;
    localparam logic [1:0] DIR_ZERO = 2'h0;
    localparam logic [1:0] DIR_NEG  = 2'h3;
    localparam logic [1:0] SRC_NONE = 2'h0;

    typedef enum logic [1:0] {
        HSI_ST_FAILED = 2'b00,
        HSI_ST_MOVING = 2'b01,
        HSI_ST_FOUND  = 2'b11
    } hsi_state_t;

    typedef enum logic [1:0] {
        HSI_IDX_INTERNAL = 2'h0,
        HSI_IDX_SYNC     = 2'h1,
        HSI_IDX_FRONT_IN_PLACE_INPUT    = 2'h2,
        HSI_IDX_REAR_ENCODER_INPUT    = 2'h3
    } hsi_idx_t;

    localparam logic [3:0] SEL_AXIS   = 4'h0;
    localparam logic [3:0] SEL_MEAS   = 4'h1;
    localparam logic [3:0] SEL_POSITION_ERROR_VALUE = 4'h2;
    localparam logic [3:0] SEL_LAST   = 4'h8;
    localparam int         NUM_REGS   = 9;

    // Status keywords; the status register reports all but KW_LINKED.
    localparam logic [1:0] KW_FAILED = 2'h0;
    localparam logic [1:0] KW_MOVING = 2'h1;
    localparam logic [1:0] KW_FOUND  = 2'h2;
    localparam logic [1:0] KW_LINKED = 2'h3;

    typedef struct packed {
        logic       start;
        logic [1:0] dir;
    } hsi_req_t;

endpackage

// ### rtl/hsi_capture.sv
`timescale 1ns/100ps
module hsi_capture #(
    parameter int W = 32
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // Holds one position value sampled on the homing event.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '0;
        else if (load)
            q <= d;
    end

endmodule

// ### rtl/hsi_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module hsi_top #(
    parameter int          NUM_IN     = hsi_pkg::NUM_REGS, // Captured registers per bank.
    parameter int          PW         = 32,
    parameter logic [31:0] HW_IDENT   = 32'h1234_5678,  // Arbitrary value.
    parameter logic [31:0] SERIAL_NUM = 32'h0000_0001   // Arbitrary value.
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 home_signal,
    input  wire logic                 search_done,
    input  wire logic                 search_ok,
    input  wire logic [NUM_IN*PW-1:0] pos_in,
    input  wire logic [NUM_IN*PW-1:0] pos_axis_units,
    output logic                      search_start,
    output logic [1:0]                search_dir,
    output logic                      search_active,
    output logic [1:0]                indexer_source,
    output logic                      indexer_linked,
    output logic                      irq
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       home_lvl;
    logic       done_s;
    logic       ok_s;
    logic       done_d_reg;

    // Home level and sequencer results come from outside the clock domain.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg  <= 3'h0;
            sync2_reg  <= 3'h0;
            done_d_reg <= 1'b0;
        end
        else
        begin
            sync1_reg  <= {search_ok, search_done, home_signal};
            sync2_reg  <= sync1_reg;
            done_d_reg <= sync2_reg[1];
        end
    end

    assign home_lvl = sync2_reg[0];
    assign done_s   = sync2_reg[1] & ~done_d_reg;
    assign ok_s     = sync2_reg[2];

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        wr_fire;
    logic        wr_ok;
    logic [7:0]  waddr;

    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign waddr   = awaddr_reg;
    assign wr_ok   = (waddr == hsi_pkg::ADDR_CMD) || (waddr == hsi_pkg::ADDR_CFG)
                  || (waddr == hsi_pkg::ADDR_QSEL) || (waddr == hsi_pkg::ADDR_IDX)
                  || (waddr == hsi_pkg::ADDR_IRQ_STAT) || (waddr == hsi_pkg::ADDR_IRQ_MASK);

    // Address and data are latched independently, then answered together.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_ok ? 2'h0 : 2'h2; // SLVERR when unmapped.
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // ----------------------------------------------------------------
    // Software registers and decode
    // ----------------------------------------------------------------
    logic [31:0] cfg_reg;
    logic [31:0] qsel_reg;
    localparam int IRQ_W = hsi_pkg::IRQ_WIDTH;
    logic [1:0]  idx_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;

    logic wr_cmd;
    logic wr_cfg;
    logic wr_qsel;
    logic wr_idx;
    logic wr_istat;
    logic wr_imask;
    assign wr_cmd   = wr_fire && waddr == hsi_pkg::ADDR_CMD && wstrb_reg[0];
    assign wr_cfg   = wr_fire && waddr == hsi_pkg::ADDR_CFG;
    assign wr_qsel  = wr_fire && waddr == hsi_pkg::ADDR_QSEL && wstrb_reg[0];
    assign wr_idx   = wr_fire && waddr == hsi_pkg::ADDR_IDX && wstrb_reg[0];
    assign wr_istat = wr_fire && waddr == hsi_pkg::ADDR_IRQ_STAT && wstrb_reg[0];
    assign wr_imask = wr_fire && waddr == hsi_pkg::ADDR_IRQ_MASK && wstrb_reg[0];

    // Fields of the configuration word.
    logic [1:0] ref_source;
    logic       auto_direction_flag;
    logic       driver_board;
    logic       link_mode;
    logic [1:0] default_idx;
    assign ref_source          = cfg_reg[hsi_pkg::CFG_SRC_LSB +: 2];
    assign auto_direction_flag = cfg_reg[hsi_pkg::CFG_AUTO_BIT];
    assign driver_board        = cfg_reg[hsi_pkg::CFG_DRV_BIT];
    assign link_mode           = cfg_reg[hsi_pkg::CFG_LINK_BIT];
    assign default_idx         = cfg_reg[hsi_pkg::CFG_DEFIDX_LSB +: 2];

    // Byte-lane merge for the configuration word.
    logic [31:0] cfg_merged;
    always_comb
    begin
        cfg_merged = cfg_reg;
        for (int i = 0; i < 4; i++)
            if (wstrb_reg[i])
                cfg_merged[8*i +: 8] = wdata_reg[8*i +: 8];
    end

    // ----------------------------------------------------------------
    // Home search command checking
    // ----------------------------------------------------------------
    hsi_pkg::hsi_req_t req;
    logic       dir_zero;
    logic       dir_bad;
    logic       req_refused;
    logic       req_accept;
    logic [1:0] start_dir;
    assign req         = {wr_cmd & wdata_reg[hsi_pkg::CMD_START_BIT],
                          wdata_reg[hsi_pkg::CMD_DIR_LSB +: 2]};
    assign dir_zero    = req.dir == hsi_pkg::DIR_ZERO;
    assign dir_bad     = req.dir == 2'h2;
    assign req_refused = req.start & ((ref_source == hsi_pkg::SRC_NONE)
                       | (dir_zero & ~auto_direction_flag)
                       | dir_bad);
    assign req_accept  = req.start & ~req_refused;
    // Zero direction follows the home level: high searches negative.
    assign start_dir   = dir_zero ? (home_lvl ? hsi_pkg::DIR_NEG : hsi_pkg::DIR_POS)
                                  : req.dir;

    // ----------------------------------------------------------------
    // Search state
    // ----------------------------------------------------------------
    hsi_pkg::hsi_state_t state_reg;
    hsi_pkg::hsi_state_t state_next;
    logic [1:0] dir_reg;
    logic       valid_reg;
    logic       capture;
    logic       abort;
    logic       start_go;
    assign abort   = wr_cmd & wdata_reg[hsi_pkg::CMD_ABORT_BIT];
    // A start while a search runs is ignored, so only an idle search launches.
    assign start_go = req_accept && state_reg != hsi_pkg::HSI_ST_MOVING;
    assign capture = (state_reg == hsi_pkg::HSI_ST_MOVING) & done_s & ok_s;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            hsi_pkg::HSI_ST_MOVING:
                if (abort || (done_s && !ok_s))
                    state_next = hsi_pkg::HSI_ST_FAILED;
                else if (done_s)
                    state_next = hsi_pkg::HSI_ST_FOUND;
            hsi_pkg::HSI_ST_FAILED,
            hsi_pkg::HSI_ST_FOUND:
                if (req_accept)
                    state_next = hsi_pkg::HSI_ST_MOVING;
            default:
                state_next = hsi_pkg::HSI_ST_FAILED;
        endcase
    end

    // State, direction and capture validity of the search.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= hsi_pkg::HSI_ST_FAILED;
            dir_reg   <= hsi_pkg::DIR_ZERO;
            valid_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (req_accept && state_reg != hsi_pkg::HSI_ST_MOVING)
            begin
                dir_reg   <= start_dir;
                valid_reg <= 1'b0;
            end
            else if (state_next == hsi_pkg::HSI_ST_FAILED && state_reg == hsi_pkg::HSI_ST_MOVING)
                dir_reg <= hsi_pkg::DIR_ZERO;
            if (capture)
                valid_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Position capture bank
    // ----------------------------------------------------------------
    logic [PW-1:0] cap_enc [NUM_IN];
    logic [PW-1:0] cap_axu [NUM_IN];
    genvar g;
    generate
        for (g = 0; g < NUM_IN; g++)
        begin : g_cap
            hsi_capture #(.W(PW)) u_enc (
                .aclk    (aclk),
                .aresetn (aresetn),
                .load    (capture),
                .d       (pos_in[g*PW +: PW]),
                .q       (cap_enc[g])
            );
            hsi_capture #(.W(PW)) u_axu (
                .aclk    (aclk),
                .aresetn (aresetn),
                .load    (capture),
                .d       (pos_axis_units[g*PW +: PW]),
                .q       (cap_axu[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Query selection
    // ----------------------------------------------------------------
    logic [3:0]  qsel;
    logic [3:0]  sel_eff;
    logic        sel_bad;
    logic        q_err;
    logic [31:0] q_value;
    assign qsel    = qsel_reg[hsi_pkg::QSEL_SEL_LSB +: 4];
    assign sel_eff = qsel_reg[hsi_pkg::QSEL_GIVEN_BIT] ? qsel : hsi_pkg::SEL_AXIS;
    assign sel_bad = (sel_eff > hsi_pkg::SEL_LAST)
                  || (sel_eff > hsi_pkg::SEL_POSITION_ERROR_VALUE && !driver_board);
    assign q_err   = ~valid_reg | sel_bad;
    assign q_value = q_err ? 32'h0000_0000
                   : qsel_reg[hsi_pkg::QSEL_UNIT_BIT] ? 32'(cap_axu[sel_eff])
                                                      : 32'(cap_enc[sel_eff]);

    // Status word: keyword, direction, capture-valid, error.
    logic [1:0]  kw;
    logic [1:0]  rep_dir;
    logic [31:0] stat_word;
    assign kw        = state_reg == hsi_pkg::HSI_ST_MOVING ? hsi_pkg::KW_MOVING
                     : state_reg == hsi_pkg::HSI_ST_FOUND  ? hsi_pkg::KW_FOUND
                                                            : hsi_pkg::KW_FAILED;
    assign rep_dir   = state_reg == hsi_pkg::HSI_ST_FAILED ? hsi_pkg::DIR_ZERO : dir_reg;
    assign stat_word = {26'h0, q_err, valid_reg, rep_dir, kw};

    // Indexer readback: linked replaces internal.
    logic [2:0] idx_rep;
    assign idx_rep = (idx_reg == hsi_pkg::HSI_IDX_INTERNAL && link_mode) ? 3'h4
                                                                          : {1'b0, idx_reg};

    // ----------------------------------------------------------------
    // Register state and events
    // ----------------------------------------------------------------
    logic [IRQ_W-1:0] ev;
    assign ev = {req_refused, done_s & (state_reg == hsi_pkg::HSI_ST_MOVING) & ~ok_s, capture};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_reg      <= hsi_pkg::CFG_RESET;
            qsel_reg     <= hsi_pkg::QSEL_RESET;
            idx_reg      <= hsi_pkg::HSI_IDX_INTERNAL;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end
        else
        begin
            if (wr_cfg)
                cfg_reg <= cfg_merged;
            if (wr_qsel)
                qsel_reg <= {25'h0, wdata_reg[6:0]};
            if (wr_idx)
                idx_reg <= wdata_reg[hsi_pkg::IDX_GIVEN_BIT] ? wdata_reg[1:0]
                                                             : default_idx;
            if (wr_imask)
                irq_mask_reg <= wdata_reg[IRQ_W-1:0];
            // Set wins over a same-cycle write-one-to-clear.
            irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? wdata_reg[IRQ_W-1:0] : '0)) | ev;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rd_mux;
    logic        rd_hit;
    logic [31:0] ident;
    assign ident = qsel_reg[hsi_pkg::QSEL_SN_BIT] ? SERIAL_NUM : HW_IDENT;

    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            hsi_pkg::ADDR_CMD:      rd_mux = {29'h0, dir_reg, state_reg == hsi_pkg::HSI_ST_MOVING};
            hsi_pkg::ADDR_CFG:      rd_mux = cfg_reg;
            hsi_pkg::ADDR_STAT:     rd_mux = stat_word;
            hsi_pkg::ADDR_QSEL:     rd_mux = qsel_reg;
            hsi_pkg::ADDR_QDATA:    rd_mux = q_value;
            hsi_pkg::ADDR_IDX:      rd_mux = {29'h0, idx_rep};
            hsi_pkg::ADDR_IDENT:    rd_mux = ident;
            hsi_pkg::ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
            hsi_pkg::ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
            default:                rd_hit = 1'b0;
        endcase
    end

    // One read at a time; data held until taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            // Query of capture with error answers SLVERR.
            rresp_reg  <= (!rd_hit || (s_axi_araddr == hsi_pkg::ADDR_QDATA && q_err))
                          ? 2'h2 : 2'h0;
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            search_start   <= 1'b0;
            search_dir     <= hsi_pkg::DIR_ZERO;
            search_active  <= 1'b0;
            indexer_source <= hsi_pkg::HSI_IDX_INTERNAL;
            indexer_linked <= 1'b0;
            irq            <= 1'b0;
        end
        else
        begin
            search_start   <= start_go;
            search_dir     <= state_next != hsi_pkg::HSI_ST_MOVING ? hsi_pkg::DIR_ZERO
                            : start_go ? start_dir : dir_reg;
            search_active  <= state_next == hsi_pkg::HSI_ST_MOVING;
            indexer_source <= idx_reg;
            indexer_linked <= link_mode && idx_reg == hsi_pkg::HSI_IDX_INTERNAL;
            irq            <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule

// ### verification/hsi_checker.sv
`timescale 1ns/100ps
module hsi_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        search_start,
    input wire logic [1:0]  search_dir,
    input wire logic        search_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read address taken on this edge.
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_start_pulse: assert property (search_start |=> !search_start)
        else $error("start longer than one cycle");
    a_start_active: assert property (search_start |=> search_active)
        else $error("search not active after start");
    a_start_dir: assert property (search_start |-> search_dir inside {2'h1, 2'h3})
        else $error("start without direction");
    a_active_dir: assert property (search_active |-> search_dir != 2'h0)
        else $error("no direction while searching");
    a_idle_dir: assert property (!search_active |-> search_dir == 2'h0)
        else $error("direction while idle");
endmodule
bind hsi_top hsi_checker u_hsi_checker (.*);

// ### verification/hsi_seq_model.sv
`timescale 1ns/100ps
module hsi_seq_model #(
    parameter int DLY = 40
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic search_start,
    input  wire logic ok_mode,
    output logic      search_done = 1'h0,
    output logic      search_ok = 1'h1
);
    int cnt = 0;
    // Ends each accepted search DLY+1 cycles after the start pulse with the commanded outcome.
    always @(posedge aclk)
        if (!aresetn || search_start) begin
            search_done <= 1'h0;
            search_ok <= ~search_ok;
            cnt <= DLY;
        end else if (cnt > 0) cnt <= cnt - 1;
        else begin
            search_done <= 1'h1;
            search_ok <= ok_mode;
        end
endmodule

// ### verification/test_home_search_and_indexer_select.sv
`timescale 1ns/100ps
module test_home_search_and_indexer_select;
    localparam logic [31:0] HW_ID = 32'hA5A5_0001; // Arbitrary value.
    localparam logic [31:0] SN_ID = 32'h0000_0C3D; // Arbitrary value.
    logic aclk = 1'h0, aresetn = 1'h0, home_signal = 1'h0, ok_mode = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, base = 32'h1000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, search_dir, indexer_source;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic search_done, search_ok, search_start, search_active, indexer_linked, irq;
    logic [hsi_pkg::NUM_REGS*32-1:0] pos_in, pos_axis_units;
    int err_count = 0, samples_checked = 0;
    // Live positions: encoder word i is base+i, axis word is 0x100 above.
    always_comb for (int i = 0; i < hsi_pkg::NUM_REGS; i++) begin
        pos_in[i*32+:32] = base + i;
        pos_axis_units[i*32+:32] = base + i + 32'h100;
    end
    hsi_top #(.HW_IDENT(HW_ID), .SERIAL_NUM(SN_ID)) u_hsi_top (.*);
    hsi_seq_model u_hsi_seq_model (.*);
    always #5 aclk = ~aclk;
    task automatic check(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        check("bresp", r, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        check($sformatf("read %h", a), e, s_axi_rdata & m);
        check("rresp", r, s_axi_rresp);
    endtask
    task automatic wait_idle;
        while (search_active !== 1'h0) @(posedge aclk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watchdog: the whole run needs well under 20000 cycles.
    initial begin
        #200000;
        err_count++;
        finish_test;
    end
    // Main sequence of tests.
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(hsi_pkg::ADDR_IDENT, HW_ID, 2'h0);
        wr(hsi_pkg::ADDR_QSEL, 32'h40, 2'h0);
        rd(hsi_pkg::ADDR_IDENT, SN_ID, 2'h0);
        $display("test identity done");
        wr(hsi_pkg::ADDR_CMD, 32'h3, 2'h0);
        rd(hsi_pkg::ADDR_IRQ_STAT, 32'h4, 2'h0);
        check("irq", 32'h0, irq);
        wr(hsi_pkg::ADDR_IRQ_MASK, 32'h7, 2'h0);
        rd(hsi_pkg::ADDR_IRQ_MASK, 32'h7, 2'h0);
        check("irq", 32'h1, irq);
        wr(hsi_pkg::ADDR_IRQ_MASK, 32'h0, 2'h0);
        wr(hsi_pkg::ADDR_IRQ_STAT, 32'h4, 2'h0);
        rd(hsi_pkg::ADDR_IRQ_STAT, 32'h0, 2'h0);
        check("irq", 32'h0, irq);
        wr(hsi_pkg::ADDR_CFG, 32'h1, 2'h0);
        wr(hsi_pkg::ADDR_CMD, 32'h1, 2'h0);
        rd(hsi_pkg::ADDR_IRQ_STAT, 32'h4, 2'h0);
        check("active", 32'h0, search_active);
        $display("test refusals done");
        home_signal <= 1'h1;
        wr(hsi_pkg::ADDR_QSEL, 32'h0, 2'h0);
        wr(hsi_pkg::ADDR_CFG, 32'h5, 2'h0);
        wr(hsi_pkg::ADDR_CMD, 32'h1, 2'h0);
        rd(hsi_pkg::ADDR_CMD, 32'h7, 2'h0);
        rd(hsi_pkg::ADDR_STAT, 32'hD, 2'h0, 32'h1F);
        wait_idle;
        base <= 32'h5000;
        rd(hsi_pkg::ADDR_STAT, 32'h1E, 2'h0, 32'h1F);
        rd(hsi_pkg::ADDR_QDATA, 32'h1000, 2'h0);
        wr(hsi_pkg::ADDR_QSEL, 32'h12, 2'h0);
        rd(hsi_pkg::ADDR_QDATA, 32'h1002, 2'h0);
        wr(hsi_pkg::ADDR_QSEL, 32'h30, 2'h0);
        rd(hsi_pkg::ADDR_QDATA, 32'h1100, 2'h0);
        wr(hsi_pkg::ADDR_QSEL, 32'h15, 2'h0);
        rd(hsi_pkg::ADDR_QDATA, 32'h0, 2'h2);
        wr(hsi_pkg::ADDR_CFG, 32'hD, 2'h0);
        rd(hsi_pkg::ADDR_QDATA, 32'h1005, 2'h0);
        $display("test capture done");
        ok_mode <= 1'h0;
        // Driver bit set, so only the missing capture can make the query fail.
        wr(hsi_pkg::ADDR_CFG, 32'h9, 2'h0);
        wr(hsi_pkg::ADDR_CMD, 32'h3, 2'h0);
        rd(hsi_pkg::ADDR_CMD, 32'h3, 2'h0);
        rd(hsi_pkg::ADDR_QDATA, 32'h0, 2'h2);
        wait_idle;
        rd(hsi_pkg::ADDR_STAT, 32'h0, 2'h0, 32'h1F);
        rd(hsi_pkg::ADDR_IRQ_STAT, 32'h2, 2'h0, 32'h2);
        $display("test failure done");
        wr(hsi_pkg::ADDR_CFG, 32'h211, 2'h0);
        for (int s = 0; s < 4; s++) begin
            wr(hsi_pkg::ADDR_IDX, 32'h4 | s, 2'h0);
            rd(hsi_pkg::ADDR_IDX, (s == 0) ? 32'h4 : s, 2'h0);
            check("indexer", s, indexer_source);
            check("linked", s == 0, indexer_linked);
        end
        wr(hsi_pkg::ADDR_IDX, 32'h0, 2'h0);
        rd(hsi_pkg::ADDR_IDX, 32'h2, 2'h0);
        wr(8'h40, 32'h0, 2'h2);
        rd(8'h44, 32'h0, 2'h2, 32'h0);
        $display("test indexer done");
        finish_test;
    end
endmodule
